// ===== rtl/dgt_defines.vh
`ifndef DGT_DEFINES_VH
`define DGT_DEFINES_VH
`define DGT_ADDR_AUXA_CTL 8'h00
`define DGT_ADDR_CORE_CTL 8'h04
`define DGT_ADDR_AUXB_CTL 8'h08
`define DGT_ADDR_SAUX_CTL 8'h0c
`define DGT_ADDR_SCORE_CTL 8'h10
`define DGT_ADDR_AUXA_CNT 8'h20
`define DGT_ADDR_CORE_CNT 8'h24
`define DGT_ADDR_AUXB_CNT 8'h28
`define DGT_ADDR_SAUX_CNT 8'h2c
`define DGT_ADDR_SCORE_CNT 8'h30
`define DGT_ADDR_CAPTURE_RELOAD_REG 8'h34
`define DGT_ADDR_STATUS 8'h38
`define DGT_CTL_RUN 0
`define DGT_CTL_DOWN 1
`define DGT_CTL_EXTDIR 2
`define DGT_CTL_MODE_LO 3
`define DGT_CTL_MODE_HI 4
`define DGT_CTL_PRE_LO 5
`define DGT_CTL_PRE_HI 7
`define DGT_CTL_SPEC_LO 8
`define DGT_CTL_SPEC_HI 9
`define DGT_CTL_TRIG_LO 10
`define DGT_CTL_TRIG_HI 11
`define DGT_CTL_OUTEN 12
`define DGT_CTL_CLR 13
`define DGT_MODE_TIMER 2'h0
`define DGT_MODE_COUNTER 2'h1
`define DGT_MODE_GATED 2'h2
`define DGT_MODE_INCR 2'h3
`define DGT_SPEC_NONE 2'h0
`define DGT_SPEC_CAPT 2'h1
`define DGT_SPEC_RELOAD 2'h2
`define DGT_SPEC_CHAIN 2'h3
`define DGT_G1_BASE_DIV 4
`define DGT_G2_BASE_DIV 2
`define DGT_CTL_RESET 16'h0000
`endif

// ===== rtl/dgt_timer.v
`timescale 1ns/1ns
// One 16-bit up/down count stage with wrap detection
module dgt_timer #(
    parameter WIDTH = 16
) (
    clk,
    reset_n,
    tick,
    down,
    load,
    load_val,
    count,
    wrap
);
    input wire clk;
    input wire reset_n;
    input wire tick;
    input wire down;
    input wire load;
    input wire [WIDTH-1:0] load_val;
    output reg [WIDTH-1:0] count;
    output wire wrap;

    // Wrap ignores load so a reload taken on the wrap cannot loop back into it
    assign wrap = tick &&
        (down ? (count == {WIDTH{1'b0}}) : (count == {WIDTH{1'b1}}));

    always @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
            count <= {WIDTH{1'b0}};
        else if (load)
            count <= load_val;
        else if (tick)
            count <= down ? count - 1'b1 : count + 1'b1;
    end
endmodule

// ===== rtl/dgt_unit.v
`timescale 1ns/1ns
`include "dgt_defines.vh"
// Contract
// - Five 16-bit timers; group one has three, group two two plus capture/reload.
// - Each auxiliary timer runs alone or chains to the core timer of its group.
// - Group one timers select timer, gated, counter or incremental mode.
// - Timer mode counts prescaled clock; counter mode counts input pin events.
// - Gated mode counts prescaled clocks only while the gate pin is high.
// - Group one finest resolution is four system clocks.
// - Direction set by software, optionally flipped by direction pin level.
// - Incremental mode decodes quadrature inputs into count and direction.
// - Core toggle latch flips on wrap, drives pin, clocks auxiliary timers.
// - Auxiliary timer configured as capture or reload stops counting.
// - Capture copies core count into auxiliary timer on input pin event.
// - Reload loads core from auxiliary on pin event or toggle latch edge.
// - Both auxiliaries reloading on opposite latch edges give a steady waveform.
// - Group two finest resolution is two system clocks.
// - Group two timers clock from prescaled clock or external signals.
// - Second toggle latch flips on wrap, clocks second aux, drives pin.
// - Second core wrap feeds compare unit and may reload from capture register.
// - Capture pin edge copies second aux into capture register, optional clear.
// - Capture may instead trigger on core timer input or direction edges.
module dgt_unit (
    clk,
    reset_n,
    addr,
    wdata,
    wr_en,
    rd_en,
    rdata,
    timer_input_pin,
    direction_input_pin,
    capture_input_pin,
    core_toggle_out_pin,
    second_toggle_out_pin,
    compare_clock_out
);
    input wire clk;
    input wire reset_n;
    input wire [7:0] addr;
    input wire [15:0] wdata;
    input wire wr_en;
    input wire rd_en;
    output reg [15:0] rdata;
    // Index 0 aux_timer_a, 1 core_timer, 2 aux_timer_b, 3 second_aux, 4 second_core
    input wire [4:0] timer_input_pin;
    input wire [4:0] direction_input_pin;
    input wire capture_input_pin;
    output reg core_toggle_out_pin;
    output reg second_toggle_out_pin;
    output reg compare_clock_out;

    localparam NT = 5;

    function [2:0] edge_of;
        input [1:0] sel;
        input prev;
        input cur;
        begin
            case (sel)
                2'h1: edge_of = {2'b00, cur & ~prev};
                2'h2: edge_of = {2'b00, ~cur & prev};
                2'h3: edge_of = {2'b00, cur ^ prev};
                default: edge_of = 3'h0;
            endcase
        end
    endfunction

    reg [15:0] ctl_q [0:NT-1];
    reg [15:0] capture_reload_reg_q;
    reg [4:0] tin_s1_q, tin_s2_q, tin_p_q;
    reg [4:0] dir_s1_q, dir_s2_q, dir_p_q;
    reg cap_s1_q, cap_s2_q, cap_p_q;
    reg [9:0] pre_cnt_q;
    reg core_latch_q, second_latch_q;
    reg [1:0] g1_base_q;
    reg g2_base_q;
    reg [4:0] wrap_sticky_q;

    wire [15:0] count [0:NT-1];
    wire [NT-1:0] wrap;
    reg [NT-1:0] tick;
    reg [NT-1:0] down;
    reg [NT-1:0] load;
    reg [15:0] load_val [0:NT-1];
    reg [NT-1:0] sw_wr;
    reg [NT-1:0] pre_tick;
    reg [NT-1:0] ext_ev;
    reg [NT-1:0] quad_ev;
    reg [NT-1:0] quad_dir;
    reg core_latch_d, second_latch_d;
    reg lat_rise, lat_fall;
    reg cap_trig;
    reg [2:0] e;
    reg [2:0] ce;
    integer i;
    integer j;
    integer k;

    // The third stage keeps the last sample so edges need no extra state
    always @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            tin_s1_q <= 5'h00;
            tin_s2_q <= 5'h00;
            tin_p_q <= 5'h00;
            dir_s1_q <= 5'h00;
            dir_s2_q <= 5'h00;
            dir_p_q <= 5'h00;
            cap_s1_q <= 1'b0;
            cap_s2_q <= 1'b0;
            cap_p_q <= 1'b0;
        end
        else
        begin
            tin_s1_q <= timer_input_pin;
            tin_s2_q <= tin_s1_q;
            tin_p_q <= tin_s2_q;
            dir_s1_q <= direction_input_pin;
            dir_s2_q <= dir_s1_q;
            dir_p_q <= dir_s2_q;
            cap_s1_q <= capture_input_pin;
            cap_s2_q <= cap_s1_q;
            cap_p_q <= cap_s2_q;
        end
    end

    // Base enables: group one every 4 clocks, group two every 2
    always @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            g1_base_q <= 2'h0;
            g2_base_q <= 1'b0;
            pre_cnt_q <= 10'h000;
        end
        else
        begin
            g1_base_q <= g1_base_q + 2'h1;
            g2_base_q <= ~g2_base_q;
            if (g2_base_q)
                pre_cnt_q <= pre_cnt_q + 10'h001;
        end
    end

    // Prescaler 2^n of the base rate, one shared ripple counter
    always @*
    begin
        for (j = 0; j < NT; j = j + 1)
        begin
            // Group one base pulses always meet an odd shared count, so bit 0 is skipped
            if (j < 3)
                pre_tick[j] = (g1_base_q == 2'h3) &&
                    ((pre_cnt_q[9:1] & ((9'h001 << ctl_q[j][`DGT_CTL_PRE_HI:`DGT_CTL_PRE_LO])
                    - 9'h001)) == 9'h000);
            else
                pre_tick[j] = g2_base_q &&
                    ((pre_cnt_q & ((10'h001 << ctl_q[j][`DGT_CTL_PRE_HI:`DGT_CTL_PRE_LO])
                    - 10'h001)) == 10'h000);
            e = edge_of(ctl_q[j][`DGT_CTL_TRIG_HI:`DGT_CTL_TRIG_LO], tin_p_q[j], tin_s2_q[j]);
            ext_ev[j] = e[0];
            // Any edge on A or B is one quadrature step
            quad_ev[j] = (tin_p_q[j] ^ tin_s2_q[j]) | (dir_p_q[j] ^ dir_s2_q[j]);
            quad_dir[j] = (tin_p_q[j] ^ tin_s2_q[j]) ? ~(tin_s2_q[j] ^ dir_s2_q[j])
                : (dir_s2_q[j] ^ tin_s2_q[j]);
        end
    end

    // Latch edges for reload triggers
    always @*
    begin
        core_latch_d = core_latch_q ^ wrap[1];
        second_latch_d = second_latch_q ^ wrap[4];
        lat_rise = wrap[1] & ~core_latch_q;
        lat_fall = wrap[1] & core_latch_q;
        cap_trig = 1'b0;
        ce = edge_of(ctl_q[3][`DGT_CTL_TRIG_HI:`DGT_CTL_TRIG_LO], cap_p_q, cap_s2_q);
        cap_trig = ce[0];
        // Core pin capture replaces the capture pin rather than adding to it
        if (ctl_q[3][`DGT_CTL_OUTEN])
            cap_trig = (tin_p_q[1] ^ tin_s2_q[1]) | (dir_p_q[1] ^ dir_s2_q[1]);
    end

    // Tick, direction and load selection per timer
    always @*
    begin
        for (i = 0; i < NT; i = i + 1)
        begin
            sw_wr[i] = wr_en && (addr == `DGT_ADDR_AUXA_CNT + 8'h04 * i[7:0]);
            down[i] = ctl_q[i][`DGT_CTL_DOWN] ^
                (ctl_q[i][`DGT_CTL_EXTDIR] & dir_s2_q[i]);
            tick[i] = 1'b0;
            load[i] = sw_wr[i];
            load_val[i] = wdata;
            case (ctl_q[i][`DGT_CTL_MODE_HI:`DGT_CTL_MODE_LO])
                `DGT_MODE_TIMER: tick[i] = pre_tick[i];
                `DGT_MODE_COUNTER: tick[i] = ext_ev[i];
                `DGT_MODE_GATED: tick[i] = pre_tick[i] & tin_s2_q[i];
                `DGT_MODE_INCR:
                begin
                    tick[i] = quad_ev[i];
                    down[i] = quad_dir[i] ^ ctl_q[i][`DGT_CTL_DOWN];
                end
                default: tick[i] = 1'b0;
            endcase
            if (ctl_q[i][`DGT_CTL_SPEC_HI:`DGT_CTL_SPEC_LO] == `DGT_SPEC_CHAIN)
            begin
                // Chained: count on latch change of the group's core timer
                if (i == 0 || i == 2)
                    tick[i] = wrap[1];
                else if (i == 3)
                    tick[i] = wrap[4];
            end
            // A capture or reload register must hold its value, so it never counts
            if ((i == 0 || i == 2) &&
                (ctl_q[i][`DGT_CTL_SPEC_HI:`DGT_CTL_SPEC_LO] == `DGT_SPEC_CAPT ||
                ctl_q[i][`DGT_CTL_SPEC_HI:`DGT_CTL_SPEC_LO] == `DGT_SPEC_RELOAD))
                tick[i] = 1'b0;
            if (!ctl_q[i][`DGT_CTL_RUN])
                tick[i] = 1'b0;
        end
        // Capture of core count into an auxiliary timer
        if (ctl_q[0][`DGT_CTL_SPEC_HI:`DGT_CTL_SPEC_LO] == `DGT_SPEC_CAPT && ext_ev[0])
        begin
            load[0] = 1'b1;
            load_val[0] = count[1];
        end
        if (ctl_q[2][`DGT_CTL_SPEC_HI:`DGT_CTL_SPEC_LO] == `DGT_SPEC_CAPT && ext_ev[2])
        begin
            load[2] = 1'b1;
            load_val[2] = count[1];
        end
        // Reload of core: option bit picks the latch edge, else the pin edge
        // A reload in a wrap cycle replaces the wrapped value
        if (ctl_q[0][`DGT_CTL_SPEC_HI:`DGT_CTL_SPEC_LO] == `DGT_SPEC_RELOAD &&
            (ctl_q[0][`DGT_CTL_CLR] ? lat_rise : ext_ev[0]))
        begin
            load[1] = 1'b1;
            load_val[1] = count[0];
        end
        if (ctl_q[2][`DGT_CTL_SPEC_HI:`DGT_CTL_SPEC_LO] == `DGT_SPEC_RELOAD &&
            (ctl_q[2][`DGT_CTL_CLR] ? lat_fall : ext_ev[2]))
        begin
            load[1] = 1'b1;
            load_val[1] = count[2];
        end
        // Second aux cleared in the same cycle as the capture when asked
        if (cap_trig && ctl_q[3][`DGT_CTL_CLR])
        begin
            load[3] = 1'b1;
            load_val[3] = 16'h0000;
        end
        if (wrap[4] && ctl_q[4][`DGT_CTL_CLR])
        begin
            load[4] = 1'b1;
            load_val[4] = capture_reload_reg_q;
        end
    end

    genvar g;
    generate
        for (g = 0; g < NT; g = g + 1)
        begin : tmr
            dgt_timer #(
                .WIDTH(16)
            ) u_timer (
                .clk(clk),
                .reset_n(reset_n),
                .tick(tick[g]),
                .down(down[g]),
                .load(load[g]),
                .load_val(load_val[g]),
                .count(count[g]),
                .wrap(wrap[g])
            );
        end
    endgenerate

    // Registers, latches and outputs
    always @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            for (k = 0; k < NT; k = k + 1)
                ctl_q[k] <= `DGT_CTL_RESET;
            capture_reload_reg_q <= 16'h0000;
            core_latch_q <= 1'b0;
            second_latch_q <= 1'b0;
            wrap_sticky_q <= 5'h00;
            core_toggle_out_pin <= 1'b0;
            second_toggle_out_pin <= 1'b0;
            compare_clock_out <= 1'b0;
            rdata <= 16'h0000;
        end
        else
        begin
            // Control words sit on four-byte steps in timer index order
            for (k = 0; k < NT; k = k + 1)
                if (wr_en && addr == `DGT_ADDR_AUXA_CTL + 8'h04 * k[7:0])
                    ctl_q[k] <= wdata;
            if (cap_trig)
                capture_reload_reg_q <= count[3];
            else if (wr_en && addr == `DGT_ADDR_CAPTURE_RELOAD_REG)
                capture_reload_reg_q <= wdata;
            core_latch_q <= core_latch_d;
            second_latch_q <= second_latch_d;
            core_toggle_out_pin <= core_latch_d & ctl_q[1][`DGT_CTL_OUTEN];
            second_toggle_out_pin <= second_latch_d & ctl_q[4][`DGT_CTL_OUTEN];
            compare_clock_out <= wrap[4];
            // Set wins over a software clear in the same cycle
            if (wr_en && addr == `DGT_ADDR_STATUS)
                wrap_sticky_q <= (wrap_sticky_q & ~wdata[4:0]) | wrap;
            else
                wrap_sticky_q <= wrap_sticky_q | wrap;
            rdata <= 16'h0000;
            if (rd_en)
            begin
                // Unmapped addresses fall to the default and read as zero
                case (addr)
                    `DGT_ADDR_AUXA_CTL: rdata <= ctl_q[0];
                    `DGT_ADDR_CORE_CTL: rdata <= ctl_q[1];
                    `DGT_ADDR_AUXB_CTL: rdata <= ctl_q[2];
                    `DGT_ADDR_SAUX_CTL: rdata <= ctl_q[3];
                    `DGT_ADDR_SCORE_CTL: rdata <= ctl_q[4];
                    `DGT_ADDR_AUXA_CNT: rdata <= count[0];
                    `DGT_ADDR_CORE_CNT: rdata <= count[1];
                    `DGT_ADDR_AUXB_CNT: rdata <= count[2];
                    `DGT_ADDR_SAUX_CNT: rdata <= count[3];
                    `DGT_ADDR_SCORE_CNT: rdata <= count[4];
                    `DGT_ADDR_CAPTURE_RELOAD_REG: rdata <= capture_reload_reg_q;
                    `DGT_ADDR_STATUS: rdata <= {9'h000, second_latch_q, core_latch_q,
                        wrap_sticky_q};
                    default: rdata <= 16'h0000;
                endcase
            end
        end
    end
endmodule

// ===== tb/dgt_chk_assertions.sv
`timescale 1ns/1ns
`include "dgt_defines.vh"
module dgt_chk (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic [7:0] addr,
    input wire logic [15:0] wdata,
    input wire logic wr_en,
    input wire logic rd_en,
    input wire logic [15:0] rdata,
    input wire logic [4:0] timer_input_pin,
    input wire logic [4:0] direction_input_pin,
    input wire logic capture_input_pin,
    input wire logic core_toggle_out_pin,
    input wire logic second_toggle_out_pin,
    input wire logic compare_clock_out
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!reset_n);
    sequence s_rd_hole;
        rd_en && addr == 8'hfc;
    endsequence
    sequence s_rd_status;
        rd_en && addr == `DGT_ADDR_STATUS;
    endsequence
    sequence s_no_wr;
        !$past(wr_en) && !$past(wr_en, 2) && !$past(wr_en, 3);
    endsequence
    property p_rd_idle;
        !rd_en |=> rdata == 16'h0000;
    endproperty
    property p_hole;
        s_rd_hole |=> rdata == 16'h0000;
    endproperty
    property p_status_hi;
        s_rd_status |=> rdata[15:7] == 9'h000;
    endproperty
    property p_reset_out;
        $rose(reset_n) |-> rdata == 16'h0000 && !core_toggle_out_pin
            && !second_toggle_out_pin && !compare_clock_out;
    endproperty
    property p_cmp_gap;
        compare_clock_out |=> !compare_clock_out;
    endproperty
    property p_sec_res;
        $changed(second_toggle_out_pin) |=> $stable(second_toggle_out_pin);
    endproperty
    // A latch flip must come with a wrap pulse unless software moved the enable
    property p_sec_cause;
        $changed(second_toggle_out_pin) ##0 s_no_wr
            |-> compare_clock_out || $past(compare_clock_out) || $past(compare_clock_out, 2);
    endproperty
    property p_core_res;
        $changed(core_toggle_out_pin) |=> $stable(core_toggle_out_pin) [*3];
    endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("rdata not zero");
    a_hole: assert property (p_hole) else $error("unmapped read not zero");
    a_status_hi: assert property (p_status_hi) else $error("status spare bits");
    a_reset_out: assert property (p_reset_out) else $error("outputs after reset");
    a_cmp_gap: assert property (p_cmp_gap) else $error("wrap pulse too long");
    a_sec_res: assert property (p_sec_res) else $error("second latch too fast");
    a_sec_cause: assert property (p_sec_cause) else $error("second latch no wrap");
    a_core_res: assert property (p_core_res) else $error("core latch too fast");
endmodule
bind dgt_unit dgt_chk u_chk (.clk(clk), .reset_n(reset_n), .addr(addr), .wdata(wdata),
    .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata), .timer_input_pin(timer_input_pin),
    .direction_input_pin(direction_input_pin), .capture_input_pin(capture_input_pin),
    .core_toggle_out_pin(core_toggle_out_pin), .second_toggle_out_pin(second_toggle_out_pin),
    .compare_clock_out(compare_clock_out));

// ===== tb/dgt_pin_model.sv
`timescale 1ns/1ns
module dgt_pin_model (
    input wire logic clk,
    output wire logic [4:0] timer_input_pin,
    output wire logic [4:0] direction_input_pin,
    output wire logic capture_input_pin
);
    logic [5:0] t_q = 6'h00;
    logic [4:0] d_q = 5'h00;
    logic [1:0] ph = 2'h0;
    assign timer_input_pin = t_q[4:0];
    assign capture_input_pin = t_q[5];
    assign direction_input_pin = d_q;
    task automatic lvl(input int i, input logic a, input logic b);
        @(posedge clk);
        t_q[i] <= a;
        d_q[i] <= b;
    endtask
    // Index 5 is the capture pin; levels held long enough for the synchroniser
    task automatic pulse(input int i);
        @(posedge clk);
        t_q[i] <= 1'b1;
        repeat (6) @(posedge clk);
        t_q[i] <= 1'b0;
        repeat (6) @(posedge clk);
    endtask
    task automatic quad(input int i, input int n, input logic fwd);
        repeat (n)
        begin
            ph = fwd ? ph + 2'h1 : ph - 2'h1;
            @(posedge clk);
            t_q[i] <= ph[0] ^ ph[1];
            d_q[i] <= ph[1];
            repeat (8) @(posedge clk);
        end
    endtask
endmodule

// ===== tb/tb.sv
`timescale 1ns/1ns
`include "dgt_defines.vh"
module tb;
    logic clk = 1'b0;
    logic reset_n = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [15:0] wdata = 16'h0000;
    logic wr_en = 1'b0;
    logic rd_en = 1'b0;
    wire [15:0] rdata;
    wire [4:0] tpin;
    wire [4:0] dpin;
    wire cpin;
    wire core_out;
    wire sec_out;
    wire cmp_out;
    int mismatches = 0;
    int checked = 0;
    int ncmp = 0;
    logic [15:0] v1;
    logic [15:0] v2;
    logic [15:0] v3;
    localparam logic [15:0] run = 16'h0001;
    localparam logic [15:0] dn = 16'h0002;
    localparam logic [15:0] xd = 16'h0004;
    localparam logic [15:0] oe = 16'h1000;
    localparam logic [15:0] clr = 16'h2000;
    always #2 clk = ~clk;
    dgt_unit DUT (.clk(clk), .reset_n(reset_n), .addr(addr), .wdata(wdata), .wr_en(wr_en),
        .rd_en(rd_en), .rdata(rdata), .timer_input_pin(tpin), .direction_input_pin(dpin),
        .capture_input_pin(cpin), .core_toggle_out_pin(core_out),
        .second_toggle_out_pin(sec_out), .compare_clock_out(cmp_out));
    dgt_pin_model pm (.clk(clk), .timer_input_pin(tpin), .direction_input_pin(dpin),
        .capture_input_pin(cpin));
    always @(posedge clk) if (cmp_out === 1'b1) ncmp++;
    function automatic logic [15:0] cw(input logic [1:0] m, s, t, input logic [2:0] p);
        cw = {4'h0, t, s, p, m, 3'h0};
    endfunction
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checked++;
        if (got !== exp)
        begin
            mismatches++;
            $display("MISMATCH %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr_en <= 1'b1;
        @(posedge clk);
        wr_en <= 1'b0;
    endtask
    task automatic rv(input logic [7:0] a, output logic [15:0] v);
        @(posedge clk);
        addr <= a;
        rd_en <= 1'b1;
        @(posedge clk);
        rd_en <= 1'b0;
        #1;
        v = rdata;
    endtask
    task automatic rd(input logic [7:0] a, input logic [15:0] e);
        logic [15:0] v;
        rv(a, v);
        chk(v, e);
    endtask
    // Two reads exactly 40 clocks apart
    task automatic span(input logic [7:0] a, input logic [15:0] e);
        logic [15:0] x;
        logic [15:0] y;
        rv(a, x);
        repeat (38) @(posedge clk);
        rv(a, y);
        chk(y - x, e);
    endtask
    task end_of_test;
        if (mismatches == 0 && checked > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    initial
    begin
        repeat (20000) @(posedge clk);
        mismatches++;
        end_of_test();
    end
    initial
    begin
        repeat (12) @(posedge clk);
        reset_n <= 1'b1;
        for (int i = 0; i < 5; i++) rd(8'(i * 4), `DGT_CTL_RESET);
        rd(8'hfc, 16'h0000);
        wr(`DGT_ADDR_CORE_CNT, 16'h0100);
        wr(`DGT_ADDR_CORE_CTL, run);
        span(`DGT_ADDR_CORE_CNT, 16'h000a);
        wr(`DGT_ADDR_CORE_CTL, run | cw(0, 0, 0, 1));
        span(`DGT_ADDR_CORE_CNT, 16'h0005);
        pm.lvl(1, 0, 1);
        wr(`DGT_ADDR_CORE_CTL, run | xd);
        span(`DGT_ADDR_CORE_CNT, 16'hfff6);
        wr(`DGT_ADDR_CORE_CTL, run | xd | dn);
        span(`DGT_ADDR_CORE_CNT, 16'h000a);
        pm.lvl(1, 0, 0);
        wr(`DGT_ADDR_CORE_CTL, 16'h0000);
        wr(`DGT_ADDR_CORE_CNT, 16'h0002);
        wr(`DGT_ADDR_CORE_CTL, run | dn | oe);
        repeat (40) @(posedge clk);
        rv(`DGT_ADDR_STATUS, v1);
        chk({15'h0, v1[5]}, 16'h0001);
        chk({15'h0, core_out}, 16'h0001);
        rv(`DGT_ADDR_CORE_CNT, v1);
        chk(16'(v1 > 16'hffe0), 16'h0001);
        wr(`DGT_ADDR_CORE_CTL, 16'h0000);
        wr(`DGT_ADDR_SCORE_CNT, 16'h0000);
        wr(`DGT_ADDR_SCORE_CTL, run);
        span(`DGT_ADDR_SCORE_CNT, 16'h0014);
        wr(`DGT_ADDR_SCORE_CNT, 16'hfff0);
        wr(`DGT_ADDR_SCORE_CTL, run | oe);
        repeat (40) @(posedge clk);
        rv(`DGT_ADDR_STATUS, v1);
        chk({15'h0, v1[6]}, 16'h0001);
        chk({15'h0, sec_out}, 16'h0001);
        chk(16'(ncmp), 16'h0001);
        wr(`DGT_ADDR_SCORE_CTL, 16'h0000);
        for (int t = 1; t < 4; t++)
        begin
            wr(`DGT_ADDR_AUXA_CNT, 16'h0000);
            wr(`DGT_ADDR_AUXA_CTL, run | cw(`DGT_MODE_COUNTER, 0, 2'(t), 0));
            repeat (5) pm.pulse(0);
            rd(`DGT_ADDR_AUXA_CNT, t == 3 ? 16'h000a : 16'h0005);
        end
        wr(`DGT_ADDR_AUXB_CNT, 16'h0000);
        wr(`DGT_ADDR_AUXB_CTL, run | cw(`DGT_MODE_GATED, 0, 0, 0));
        repeat (40) @(posedge clk);
        rd(`DGT_ADDR_AUXB_CNT, 16'h0000);
        pm.lvl(2, 1, 0);
        repeat (6) @(posedge clk);
        span(`DGT_ADDR_AUXB_CNT, 16'h000a);
        pm.lvl(2, 0, 0);
        wr(`DGT_ADDR_AUXB_CTL, 16'h0000);
        wr(`DGT_ADDR_AUXA_CTL, run | cw(`DGT_MODE_INCR, 0, 0, 0));
        rv(`DGT_ADDR_AUXA_CNT, v1);
        pm.quad(0, 8, 1);
        rv(`DGT_ADDR_AUXA_CNT, v2);
        pm.quad(0, 8, 0);
        rv(`DGT_ADDR_AUXA_CNT, v3);
        chk(16'(v2 != v1), 16'h0001);
        chk(v3, v1);
        wr(`DGT_ADDR_CORE_CNT, 16'h1234);
        wr(`DGT_ADDR_AUXA_CNT, 16'h0000);
        wr(`DGT_ADDR_AUXA_CTL, run | cw(0, `DGT_SPEC_CAPT, 1, 0));
        pm.pulse(0);
        rd(`DGT_ADDR_AUXA_CNT, 16'h1234);
        repeat (20) @(posedge clk);
        rd(`DGT_ADDR_AUXA_CNT, 16'h1234);
        wr(`DGT_ADDR_AUXB_CNT, 16'h0abc);
        wr(`DGT_ADDR_AUXB_CTL, run | cw(0, `DGT_SPEC_RELOAD, 1, 0));
        pm.pulse(2);
        rd(`DGT_ADDR_CORE_CNT, 16'h0abc);
        wr(`DGT_ADDR_SAUX_CNT, 16'h0321);
        wr(`DGT_ADDR_SAUX_CTL, clr | cw(0, 0, 1, 0));
        pm.pulse(5);
        rd(`DGT_ADDR_CAPTURE_RELOAD_REG, 16'h0321);
        rd(`DGT_ADDR_SAUX_CNT, 16'h0000);
        wr(`DGT_ADDR_SAUX_CNT, 16'h0555);
        wr(`DGT_ADDR_SAUX_CTL, oe | cw(0, 0, 1, 0));
        pm.pulse(1);
        rd(`DGT_ADDR_CAPTURE_RELOAD_REG, 16'h0555);
        wr(`DGT_ADDR_SAUX_CNT, 16'h0000);
        wr(`DGT_ADDR_SAUX_CTL, run | cw(0, `DGT_SPEC_CHAIN, 0, 0));
        wr(`DGT_ADDR_SCORE_CNT, 16'hffff);
        wr(`DGT_ADDR_SCORE_CTL, run | clr);
        repeat (20) @(posedge clk);
        rv(`DGT_ADDR_SCORE_CNT, v1);
        chk(16'(v1 >= 16'h0555 && v1 < 16'h0580), 16'h0001);
        rd(`DGT_ADDR_SAUX_CNT, 16'h0001);
        wr(`DGT_ADDR_SCORE_CTL, 16'h0000);
        wr(`DGT_ADDR_AUXA_CTL, clr | cw(0, `DGT_SPEC_RELOAD, 0, 0));
        wr(`DGT_ADDR_AUXA_CNT, 16'hfff0);
        wr(`DGT_ADDR_AUXB_CNT, 16'hfff8);
        wr(`DGT_ADDR_AUXB_CTL, clr | cw(0, `DGT_SPEC_RELOAD, 0, 0));
        wr(`DGT_ADDR_CORE_CNT, 16'hfffe);
        wr(`DGT_ADDR_CORE_CTL, run | oe);
        repeat (200) @(posedge clk);
        rv(`DGT_ADDR_CORE_CNT, v1);
        chk(16'(v1 >= 16'hfff0), 16'h0001);
        end_of_test();
    end
endmodule
